// ### hw/mem_dev_seq.sv
// Memory device end: power-up initialization and hardware reset handling
//
// Function
// [RL1] Start init when supply becomes good
// [RL2] Finish init within the power-up wait
// [RL3] Held reset postpones the init wait
// [RL4] Init wait mainly performs array refresh
// [RL5] Host keeps select high through init
// [RL6] Host issues no access during init
// [RL7] Reset returns device to standby, abandons work
// [RL8] Reset restores configuration defaults
// [RL9] Self-refresh halts while reset low
// [RL10] Reset forces exit from deep power down
// [RL11] Reset clears refresh row counter
// [RL12] Host treats array as lost after reset
// [RL13] Host idle during reset and its gap
// [RL14] Select waits 200 ns after release
// [RL15] Select waits 400 ns after assert
// [RL16] Host resets after uncertain supply dip
// [RL17] Supply-good input; init counted in cycles
`timescale 1ns/10ps
`default_nettype none
`include "pwr_seq_params.svh"
module mem_dev_seq #(
  parameter int INIT_CYCLES = `POWER_UP_WAIT_CYCLES,
  parameter int ROW_BITS = 13,
  parameter int REFRESH_GAP = `REFRESH_GAP_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  pwr_seq_if.device link,
  input wire logic dpd_enter,
  input wire logic [15:0] cfg_wdata,
  input wire logic cfg_we,
  output logic ready,
  output logic refresh_pulse,
  output logic refresh_active,
  output logic [ROW_BITS-1:0] refresh_row,
  output logic [15:0] cfg_value,
  output logic deep_pd,
  output logic select_violation
);
  // Counter widths with one spare bit of headroom
  localparam int TW = $clog2(INIT_CYCLES + 1) + 1;
  localparam int GW = $clog2(REFRESH_GAP + 1) + 1;

  // All state but the init timer in one word, registered in one place
  typedef struct packed {
    pwr_seq_pkg::dev_state_t st;
    logic [ROW_BITS-1:0] row;
    logic [GW-1:0] gap;
    logic [15:0] cfg;
    logic refresh_pulse;
    logic viol;
  } dev_t;
  dev_t s_reg;
  dev_t s_next;
  // Timer handshake: load outside the wait, done once it has run out
  logic timer_load;
  logic timer_done;

  // Timer widths follow from the counts, so only the counts and ROW_BITS need guarding
  initial begin
    if (INIT_CYCLES < 1) begin
      $error("mem_dev_seq INIT_CYCLES must be at least one");
    end
    if (ROW_BITS < 1) begin
      $error("mem_dev_seq ROW_BITS must be at least one");
    end
    if (REFRESH_GAP < 1) begin
      $error("mem_dev_seq REFRESH_GAP must be at least one");
    end
  end

  // -------------------------------------------------------------------
  // Initialization wait timer
  // -------------------------------------------------------------------
  // Reloaded on every cycle outside the wait, so it starts only when init begins
  // Loaded with one less, so ready rises INIT_CYCLES edges after init starts
  cycle_timer #(
    .WIDTH(TW)
  ) init_timer (
    .mclk(mclk),
    .nrst(nrst),
    .load(timer_load),
    .count(TW'(INIT_CYCLES - 1)),
    .done(timer_done)
  );

  // -------------------------------------------------------------------
  // Sequencing state
  // -------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.refresh_pulse = 1'b0;
    timer_load = 1'b1;
    // -----------------------------------------------------------------
    // Select watch
    // -----------------------------------------------------------------
    // Select low during init, reset or deep power down is a host fault;
    // the flag is registered, so it lags the offending cycle by one edge
    s_next.viol = !link.cs_n && (s_reg.st != pwr_seq_pkg::DEV_STANDBY);

    // -----------------------------------------------------------------
    // Supply loss and hardware reset
    // -----------------------------------------------------------------
    // Supply loss outranks reset, since a dead array has nothing to keep
    if (!link.supply_good) begin
      // Losing supply drops everything; init reruns when it returns
      s_next.st = pwr_seq_pkg::DEV_OFF;
      s_next.row = ROW_BITS'(`ROW_DEFAULT);
      s_next.cfg = 16'(`CFG_DEFAULT);
      s_next.gap = '0;
    end else if (!link.reset_n) begin
      // Any activity is dropped at once; nothing waits for a row to end
      // Gap cleared so standby pacing restarts from a clean count
      s_next.st = pwr_seq_pkg::DEV_HELD; // RL7 RL10
      s_next.cfg = 16'(`CFG_DEFAULT); // RL8
      s_next.row = ROW_BITS'(`ROW_DEFAULT); // RL11
      s_next.gap = '0; // RL9
    end else begin
      // ---------------------------------------------------------------
      // Normal state walk, supply good and reset released
      // ---------------------------------------------------------------
      case (s_reg.st)
        pwr_seq_pkg::DEV_OFF: begin
          // Supply has just been seen good
          s_next.st = pwr_seq_pkg::DEV_INIT; // RL1 RL17
        end
        pwr_seq_pkg::DEV_HELD: begin
          // The init wait starts only now that reset is high
          s_next.st = pwr_seq_pkg::DEV_INIT; // RL3
        end
        pwr_seq_pkg::DEV_INIT: begin
          timer_load = 1'b0;
          if (timer_done) begin
            s_next.st = pwr_seq_pkg::DEV_STANDBY; // RL2
          end
        end
        pwr_seq_pkg::DEV_STANDBY: begin
          // Writes and power down only while deselected, so no access is cut
          if (cfg_we && link.cs_n) begin
            s_next.cfg = cfg_wdata;
          end
          if (dpd_enter && link.cs_n) begin
            s_next.st = pwr_seq_pkg::DEV_DEEP_PD;
          end
        end
        pwr_seq_pkg::DEV_DEEP_PD: begin
          // Only reset or supply loss leaves; refresh and config stay frozen
          s_next.st = pwr_seq_pkg::DEV_DEEP_PD;
        end
        default: begin
          // A broken state code falls back to a full power-up
          s_next.st = pwr_seq_pkg::DEV_OFF;
        end
      endcase
    end

    // -----------------------------------------------------------------
    // Refresh pacing
    // -----------------------------------------------------------------
    // Back-to-back refresh during init, paced refresh in standby
    // Row counter wraps, so the sweep over the array never stops
    if (link.supply_good && link.reset_n &&
        (s_reg.st == pwr_seq_pkg::DEV_INIT ||
         s_reg.st == pwr_seq_pkg::DEV_STANDBY)) begin
      if (s_reg.st == pwr_seq_pkg::DEV_INIT || s_reg.gap == '0) begin
        s_next.refresh_pulse = 1'b1; // RL4 RL9
        s_next.row = s_reg.row + 1'b1;
        s_next.gap = GW'(REFRESH_GAP - 1);
      end else begin
        s_next.gap = s_reg.gap - 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  // Reset values equal the supply-loss values, so both paths look alike
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_reg.st <= pwr_seq_pkg::DEV_OFF;
      s_reg.row <= ROW_BITS'(`ROW_DEFAULT);
      s_reg.gap <= '0;
      s_reg.cfg <= 16'(`CFG_DEFAULT);
      s_reg.refresh_pulse <= 1'b0;
      s_reg.viol <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  // Status decoded from the one-hot state register, so no extra flops
  assign ready = (s_reg.st == pwr_seq_pkg::DEV_STANDBY);
  assign refresh_active = (s_reg.st == pwr_seq_pkg::DEV_INIT) ||
                          (s_reg.st == pwr_seq_pkg::DEV_STANDBY);
  assign deep_pd = (s_reg.st == pwr_seq_pkg::DEV_DEEP_PD);

  // Data outputs come straight from flops
  assign refresh_pulse = s_reg.refresh_pulse;
  assign refresh_row = s_reg.row;
  assign cfg_value = s_reg.cfg;

  // Host fault flag, for whoever watches the link
  assign select_violation = s_reg.viol;
endmodule
`default_nettype wire

// ### hw/pwr_seq_params.svh
// Timing constants for the power-up and reset sequencing pair
`ifndef PWR_SEQ_PARAMS_SVH
`define PWR_SEQ_PARAMS_SVH
`define CLK_PERIOD_PS 4000
`define POWER_UP_WAIT_TIME_NS 150000
`define POWER_UP_WAIT_CYCLES ((`POWER_UP_WAIT_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define RESET_RELEASE_TO_SELECT_TIME_NS 200
`define RESET_RELEASE_TO_SELECT_CYCLES \
  ((`RESET_RELEASE_TO_SELECT_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_ASSERT_TO_SELECT_TIME_NS 400
`define RESET_ASSERT_TO_SELECT_CYCLES \
  ((`RESET_ASSERT_TO_SELECT_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_PULSE_TIME_NS 200
`define RESET_PULSE_CYCLES \
  ((`RESET_PULSE_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CFG_DEFAULT 16'h8F1F
`define ROW_DEFAULT 13'h0000
`define REFRESH_GAP_CYCLES 16
`endif

// ### hw/pwr_seq_pkg.sv
// Types shared by both ends of the power-up and reset link
package pwr_seq_pkg;
  typedef enum logic [4:0] {
    DEV_OFF = 5'h01,
    DEV_HELD = 5'h02,
    DEV_INIT = 5'h04,
    DEV_STANDBY = 5'h08,
    DEV_DEEP_PD = 5'h10
  } dev_state_t;
  typedef enum logic [4:0] {
    HOST_WAIT_SUPPLY = 5'h01,
    HOST_RESET_LOW = 5'h02,
    HOST_RESET_HOLD = 5'h04,
    HOST_INIT_WAIT = 5'h08,
    HOST_READY = 5'h10
  } host_state_t;
endpackage

// ### hw/pwr_seq_if.sv
// Interface joining the host controller end to the memory device end
`timescale 1ns/10ps
`default_nettype none
interface pwr_seq_if;
  logic cs_n;
  logic reset_n;
  logic supply_good;
  modport device (
    input cs_n,
    input reset_n,
    input supply_good
  );
  modport host (
    output cs_n,
    output reset_n,
    input supply_good
  );
endinterface
`default_nettype wire

// ### hw/cycle_timer.sv
// Loadable down-counter that reports when a wait has run out
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } timer_t;
  timer_t s_reg;
  timer_t s_next;

  initial begin
    if (WIDTH < 2) begin
      $error("cycle_timer WIDTH too small");
    end
  end

  // Load wins over counting so a restart is never missed
  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.cnt = count;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = (s_reg.cnt == '0) && !load;
endmodule
`default_nettype wire

// ### hw/mem_host_seq.sv
// Host controller end: drives reset and holds select off during blackouts
`timescale 1ns/10ps
`default_nettype none
`include "pwr_seq_params.svh"
module mem_host_seq #(
  parameter int INIT_CYCLES = `POWER_UP_WAIT_CYCLES,
  parameter int RELEASE_CYCLES = `RESET_RELEASE_TO_SELECT_CYCLES,
  parameter int ASSERT_CYCLES = `RESET_ASSERT_TO_SELECT_CYCLES,
  parameter int PULSE_CYCLES = `RESET_PULSE_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  pwr_seq_if.host link,
  input wire logic reset_req,
  input wire logic select_req,
  output logic access_ok,
  output logic data_lost
);
  localparam int TW = $clog2(INIT_CYCLES + ASSERT_CYCLES + 1) + 1;

  typedef struct packed {
    pwr_seq_pkg::host_state_t st;
    logic [TW-1:0] cnt;
    logic [TW-1:0] since_fall;
    logic lost;
    logic cs_n;
  } host_t;
  host_t s_reg;
  host_t s_next;

  initial begin
    // Counter is sized for the init plus assert waits; the others must fit
    if (RELEASE_CYCLES < 1 || ASSERT_CYCLES < 1 || PULSE_CYCLES < 1 ||
        INIT_CYCLES < 1 || RELEASE_CYCLES > INIT_CYCLES + ASSERT_CYCLES ||
        PULSE_CYCLES > INIT_CYCLES + ASSERT_CYCLES) begin
      $error("mem_host_seq parameters out of range");
    end
  end

  // Init wait on supply return, reset only on request; select only once all waits end
  always_comb begin
    s_next = s_reg;
    s_next.cs_n = 1'b1; // RL5 RL6 RL13
    if (s_reg.since_fall != '1) begin
      s_next.since_fall = s_reg.since_fall + 1'b1;
    end
    if (!link.supply_good) begin
      s_next.st = pwr_seq_pkg::HOST_WAIT_SUPPLY;
      s_next.cnt = '0;
    end else begin
      case (s_reg.st)
        pwr_seq_pkg::HOST_WAIT_SUPPLY: begin
          s_next.st = pwr_seq_pkg::HOST_INIT_WAIT;
          s_next.cnt = TW'(INIT_CYCLES);
        end
        pwr_seq_pkg::HOST_RESET_LOW: begin
          if (s_reg.cnt <= TW'(1)) begin
            s_next.st = pwr_seq_pkg::HOST_RESET_HOLD;
            s_next.cnt = TW'(RELEASE_CYCLES); // RL14
          end else begin
            s_next.cnt = s_reg.cnt - 1'b1;
          end
        end
        pwr_seq_pkg::HOST_RESET_HOLD: begin
          if (s_reg.cnt <= TW'(1)) begin
            s_next.st = pwr_seq_pkg::HOST_INIT_WAIT;
            s_next.cnt = TW'(INIT_CYCLES);
          end else begin
            s_next.cnt = s_reg.cnt - 1'b1;
          end
        end
        pwr_seq_pkg::HOST_INIT_WAIT: begin
          if (s_reg.cnt <= TW'(1) &&
              s_reg.since_fall >= TW'(ASSERT_CYCLES)) begin
            s_next.st = pwr_seq_pkg::HOST_READY; // RL15
          end else if (s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - 1'b1;
          end
        end
        pwr_seq_pkg::HOST_READY: begin
          s_next.cs_n = !select_req;
          if (select_req) begin
            s_next.lost = 1'b0; // Reload seen as done once used
          end
        end
        default: begin
          s_next.st = pwr_seq_pkg::HOST_WAIT_SUPPLY;
        end
      endcase
      // Request wins in any state while supply is good; covers uncertain supply dips
      if (reset_req) begin
        s_next.st = pwr_seq_pkg::HOST_RESET_LOW; // RL16
        s_next.cnt = TW'(PULSE_CYCLES);
        s_next.since_fall = '0;
        s_next.lost = 1'b1; // RL12
        s_next.cs_n = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_reg.st <= pwr_seq_pkg::HOST_WAIT_SUPPLY;
      s_reg.cnt <= '0;
      s_reg.since_fall <= '1;
      s_reg.lost <= 1'b0;
      s_reg.cs_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.reset_n = (s_reg.st != pwr_seq_pkg::HOST_RESET_LOW);
  assign link.cs_n = s_reg.cs_n;
  assign access_ok = (s_reg.st == pwr_seq_pkg::HOST_READY);
  assign data_lost = s_reg.lost;
endmodule
`default_nettype wire

// ### dv/pwr_seq_props.sv
// Checker for the select blackouts on the power-up and reset link
`timescale 1ns/10ps
`default_nettype none
`include "pwr_seq_params.svh"
module pwr_seq_props #(
  parameter int INIT_CYCLES = `POWER_UP_WAIT_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic supply_good
);
  localparam int RELEASE = `RESET_RELEASE_TO_SELECT_CYCLES;
  localparam int ASSERT = `RESET_ASSERT_TO_SELECT_CYCLES;
  logic [15:0] rise_cnt;
  logic [15:0] fall_cnt;
  logic [15:0] good_cnt;
  // ----------------------------------------
  // Ages of reset edges and of supply good
  // ----------------------------------------
  // Saturating, so a long standby never wraps back into a blackout
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rise_cnt <= 16'hFFFF;
      fall_cnt <= 16'hFFFF;
      good_cnt <= 16'h0000;
    end else begin
      rise_cnt <= !reset_n ? 16'h0000 : rise_cnt + {15'h0000, ~&rise_cnt};
      if (!reset_n && rise_cnt != 16'h0000)
        fall_cnt <= 16'h0000;
      else
        fall_cnt <= fall_cnt + {15'h0000, ~&fall_cnt};
      good_cnt <= !supply_good ? 16'h0000 : good_cnt + {15'h0000, ~&good_cnt};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  hold_in_reset_a:
    assert property (!reset_n |-> cs_n) else $error("select in reset");
  release_gap_a:
    assert property (!cs_n |-> rise_cnt >= RELEASE) else $error("early sel");
  assert_gap_a:
    assert property (!cs_n |-> fall_cnt >= ASSERT) else $error("early sel");
  init_gap_a:
    assert property (!cs_n |-> good_cnt >= INIT_CYCLES) else $error("init sel");
  supply_off_a:
    assert property (!supply_good |-> cs_n) else $error("select unpowered");
  fall_idle_a:
    assert property ($fell(reset_n) |=> cs_n [*8]) else $error("sel at fall");
  rise_idle_a:
    assert property ($rose(reset_n) |-> cs_n [*8]) else $error("sel at rise");
  power_idle_a:
    assert property ($rose(supply_good) |-> cs_n [*8]) else $error("sel at up");
endmodule
`default_nettype wire

// ### dv/test_psram_init_and_reset_seq.sv
// Self-checking bench for the power-up and reset sequencing pair
`timescale 1ns/10ps
`default_nettype none
module test_psram_init_and_reset_seq;
  localparam int INIT = 40;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic reset_req = 1'b0;
  logic select_req = 1'b0;
  logic dpd_enter = 1'b0;
  logic cfg_we = 1'b0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic ready, refresh_pulse, refresh_active, deep_pd, select_violation;
  logic [12:0] refresh_row;
  logic [15:0] cfg_value;
  logic access_ok, data_lost;
  int mismatches = 0;
  int n_tests = 0;
  int pulses = 0;
  int p0;
  int n;
  pwr_seq_if link();
  mem_dev_seq #(.INIT_CYCLES(INIT)) i_mem_dev_seq (.mclk(mclk), .nrst(nrst),
    .link(link), .dpd_enter(dpd_enter), .cfg_wdata(cfg_wdata),
    .cfg_we(cfg_we), .ready(ready), .refresh_pulse(refresh_pulse),
    .refresh_active(refresh_active), .refresh_row(refresh_row),
    .cfg_value(cfg_value), .deep_pd(deep_pd),
    .select_violation(select_violation));
  mem_host_seq #(.INIT_CYCLES(INIT)) i_mem_host_seq (.mclk(mclk),
    .nrst(nrst), .link(link), .reset_req(reset_req),
    .select_req(select_req), .access_ok(access_ok), .data_lost(data_lost));
  pwr_seq_props #(.INIT_CYCLES(INIT)) i_pwr_seq_props (.mclk(mclk),
    .nrst(nrst), .cs_n(link.cs_n), .reset_n(link.reset_n),
    .supply_good(link.supply_good));
  // 250 MHz core clock
  always #2 mclk = ~mclk;
  // Refresh pulses seen, for windows where refresh must run or halt
  always @(posedge mclk) if (refresh_pulse === 1'b1) pulses <= pulses + 1;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Settled sampling one ns past the edge
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Bounded wait on ready (0) or access_ok (1); cycle count returned
  task automatic wait_hi(input bit sel, output int k);
    k = 0;
    while ((sel ? access_ok : ready) !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    if (k == 400) check(16'h0001, 16'h0000);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is under 1000 cycles; this only cuts a hang
  initial begin
    #40000;
    mismatches++;
    conclude();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    link.supply_good <= 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    tick(1);
    check(ready, 0);
    check(cfg_value, 16'h8F1F);
    check(refresh_row, 0);
    check({deep_pd, access_ok, link.cs_n, link.reset_n}, 16'h0003);
    // Power-up, with select asked for early to see it refused
    @(posedge mclk);
    link.supply_good <= 1'b1;
    select_req <= 1'b1;
    p0 = pulses;
    tick(1);
    wait_hi(0, n);
    check(n inside {[INIT:INIT+1]}, 1);
    check(pulses > p0, 1);
    wait_hi(1, n);
    tick(1);
    check({link.cs_n, select_violation, data_lost}, 0);
    // Standby work: config write, refresh, deep power down
    @(posedge mclk);
    select_req <= 1'b0;
    tick(2);
    @(posedge mclk);
    cfg_wdata <= 16'h1234;
    cfg_we <= 1'b1;
    dpd_enter <= 1'b1;
    @(posedge mclk);
    cfg_we <= 1'b0;
    dpd_enter <= 1'b0;
    tick(40);
    check(cfg_value, 16'h1234);
    check({refresh_row > 0, deep_pd}, 16'h0003);
    // Hardware reset out of deep power down
    @(posedge mclk);
    reset_req <= 1'b1;
    @(posedge mclk);
    reset_req <= 1'b0;
    tick(2);
    check({link.reset_n, data_lost, access_ok, ready}, 16'h0004);
    check(cfg_value, 16'h8F1F);
    check(refresh_row, 0);
    check({deep_pd, refresh_active}, 0);
    p0 = pulses;
    tick(40);
    check(pulses == p0, 1);
    wait_hi(0, n);
    tick(20);
    check({refresh_active, pulses > p0}, 16'h0003);
    wait_hi(1, n);
    @(posedge mclk);
    select_req <= 1'b1;
    tick(2);
    check({link.cs_n, data_lost}, 0);
    // Supply dip, then a reset while power comes back
    // Deselect first: the host cannot outrun a supply that drops at once
    @(posedge mclk);
    select_req <= 1'b0;
    tick(2);
    check(link.cs_n, 16'h0001);
    @(posedge mclk);
    link.supply_good <= 1'b0;
    tick(3);
    check({ready, access_ok, link.cs_n}, 16'h0001);
    @(posedge mclk);
    link.supply_good <= 1'b1;
    reset_req <= 1'b1;
    @(posedge mclk);
    reset_req <= 1'b0;
    tick(1);
    wait_hi(0, n);
    check(n >= INIT + 45, 1);
    conclude();
  end
endmodule
`default_nettype wire
